// ===== dcpm_pkg.sv
// Constants, register map and state type of the CA parity and per-device MRS controller
package dcpm_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_TIMING = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  // ==========================================
  // Command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_MR_LSB  = 3;
  localparam int CMD_SKIP    = 6;
  localparam int CMD_DLL     = 7;
  // Timing register fields
  localparam int TIM_PL_LSB  = 0;
  localparam int TIM_AL_LSB  = 4;
  localparam int TIM_CWL_LSB = 8;
  localparam int TIM_BC4     = 13;
  localparam int TIM_WLDONE  = 14;
  localparam int TIM_ODTNOM  = 15;
  // Status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_PDA      = 1;
  localparam int ST_ALERT    = 2;
  localparam int ST_ERR      = 3;
  localparam int ST_DLL      = 4;
  localparam int ST_CKEN     = 5;
  localparam int ST_CKE      = 6;
  localparam int ST_RESTR    = 7;
  // ==========================================
  // Operations
  localparam logic [2:0] OP_MRS   = 3'h0;
  localparam logic [2:0] OP_PDAEN = 3'h1;
  localparam logic [2:0] OP_PDAMR = 3'h2;
  localparam logic [2:0] OP_PDAEX = 3'h3;
  localparam logic [2:0] OP_SRE   = 3'h4;
  localparam logic [2:0] OP_SRX   = 3'h5;
  localparam logic [2:0] OP_PREA  = 3'h6;
  localparam logic [2:0] OP_CKSTP = 3'h7;
  // ==========================================
  // Mode register bits
  localparam logic [2:0] MR3_SEL  = 3'h3;
  localparam int MR3_PDA_BIT = 4;
  localparam int A10_BIT     = 10;
  // ==========================================
  // Timing counts in clock cycles (plain defaults)
  localparam logic [10:0] TMOD_CYC     = 11'h018;
  localparam logic [10:0] TMRD_PDA_CYC = 11'h010;
  localparam logic [10:0] TXS_CYC      = 11'h020;
  localparam logic [10:0] TXSDLL_CYC   = 11'h300;
  localparam logic [10:0] TALERT_CYC   = 11'h00A;
  // ==========================================
  // Reset values
  localparam logic [3:0] PL_RST  = 4'h0;
  localparam logic [3:0] AL_RST  = 4'h0;
  localparam logic [4:0] CWL_RST = 5'h09;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ISSUE = 3'b001,
    S_WAIT  = 3'b011,
    S_ALERT = 3'b010,
    S_RECOV = 3'b110,
    S_CKSTP = 3'b111
  } dcpm_state_type;
endpackage

// ===== dcpm_ctrl.sv
// Host controller: CA parity error response and per-device mode register programming
`timescale 1ns/100ps

// How it works
// - Unknown window: force precharge-all after alert
// - After alert: only deselect, CKE may rise
// - Keep clock until alert detectable
// - Alert near SRX: only MRS until tXS
// - DLL-needing commands wait tXSDLL
// - Parity mode change waits tMOD plus PL
// - Hold DQ0 steady for whole burst
// - Write leveling before PDA entry
// - Enter PDA by MR3 bit4 one
// - Only MRS while PDA active
// - Space PDA MRS by full cycle time
// - Exit PDA: MR3 bit4 zero, DQ0 low
// - Exit writes whole MR3 from software
// - Even parity over command and address
// - Persistent mode via MR5 bit9
// - Clear status bit to resume checking
module dcpm_ctrl
  import dcpm_pkg::*;
(
  input  wire logic        ref_clk,   // 20 MHz clock
  input  wire logic        rst,       // Async reset, active high
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error, unmapped
  output logic             ca_cs_n,   // Chip select, low active
  output logic             ca_act_n,  // Activate, low active
  output logic      [17:0] ca_addr,   // A17..A0, A16..A14 command
  output logic      [1:0]  ca_ba,     // Bank address
  output logic      [1:0]  ca_bg,     // Bank group
  output logic             ca_par,    // Even parity
  output logic             cke,       // Clock enable
  output logic             ck_run,    // Clock gate for CK
  output logic             odt,       // ODT pin
  output logic             dq0_o,     // DQ0 drive level
  output logic             dq0_oe,    // DQ0 drive enable
  output logic             dqs_o,     // DQS level
  output logic             dqs_oe,    // DQS drive enable
  input  wire logic        alert_n    // Alert from device, low active
);

  typedef struct packed {
    dcpm_state_type st;
    logic [3:0]  pl;
    logic [3:0]  al;
    logic [4:0]  cwl;
    logic        bc4;
    logic        wl_done;
    logic        odt_nom;
    logic [17:0] data;
    logic [2:0]  op;
    logic [2:0]  mr;
    logic        skip;
    logic        need_dll;
    logic        pend;
    logic [10:0] cnt;
    logic [10:0] gap;
    logic        pda;
    logic        alert_seen;
    logic        err;
    logic        restr;
    logic [10:0] xs_cnt;
    logic [10:0] dll_cnt;
    logic        cs_n;
    logic        act_n;
    logic [17:0] addr;
    logic [1:0]  ba;
    logic [1:0]  bg;
    logic        par;
    logic        cke;
    logic        ck_run;
    logic        odt;
    logic        dq0;
    logic        dq_oe;
    logic        dqs;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        al_s1;
    logic        al_s2;
  } dcpm_regs_type;

  dcpm_regs_type q;
  dcpm_regs_type d;

  function automatic logic even_par(input logic act, input logic [17:0] a, input logic [1:0] b, input logic [1:0] g);
    even_par = ^{act, a, b, g};
  endfunction

  function automatic logic [10:0] pda_gap(input logic [3:0] al, input logic [4:0] cwl, input logic bc4,
                                          input logic [3:0] pl);
    // Half-cycle term cancels when rounded up to whole clocks
    pda_gap = 11'(al) + 11'(cwl) + (bc4 ? 11'h002 : 11'h004) + TMRD_PDA_CYC + 11'(pl);
  endfunction

  logic        setup;
  logic        wr_acc;
  logic [10:0] wl;
  logic [10:0] bhalf;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & q.pready & pwrite;
  assign wl     = 11'(q.al) + 11'(q.cwl) + 11'(q.pl);
  assign bhalf  = q.bc4 ? 11'h002 : 11'h004;

  // ==========================================
  // Next state
  always_comb
  begin
    d         = q;
    d.al_s1   = alert_n;
    d.al_s2   = q.al_s1;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.cs_n    = 1'b1;
    if (q.xs_cnt != 11'h000)
      d.xs_cnt = q.xs_cnt - 11'h001;
    else
      d.restr = 1'b0;
    if (q.dll_cnt != 11'h000)
      d.dll_cnt = q.dll_cnt - 11'h001;

    // APB slave, answers in the access cycle
    if (setup)
    begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CMD:    d.prdata = {24'h0, q.need_dll, q.skip, q.mr, q.op};
        REG_DATA:   d.prdata = {14'h0, q.data};
        REG_TIMING: d.prdata = {16'h0, q.odt_nom, q.wl_done, q.bc4, q.cwl, q.al, q.pl};
        REG_STATUS: d.prdata = {24'h0, q.restr, q.cke, q.ck_run, (q.dll_cnt == 11'h000), q.err,
                                q.alert_seen, q.pda, (q.st != S_IDLE) | q.pend};
        default:    d.pslverr = 1'b1;
      endcase
    end
    if (wr_acc)
    begin
      unique case (paddr)
        REG_CMD:
        begin
          d.op       = pwdata[CMD_OP_LSB +: 3];
          d.mr       = pwdata[CMD_MR_LSB +: 3];
          d.skip     = pwdata[CMD_SKIP];
          d.need_dll = pwdata[CMD_DLL];
          d.pend     = 1'b1;
        end
        REG_DATA:   d.data = pwdata[17:0];
        REG_TIMING:
        begin
          d.pl      = pwdata[TIM_PL_LSB +: 4];
          d.al      = pwdata[TIM_AL_LSB +: 4];
          d.cwl     = pwdata[TIM_CWL_LSB +: 5];
          d.bc4     = pwdata[TIM_BC4];
          d.wl_done = pwdata[TIM_WLDONE];
          d.odt_nom = pwdata[TIM_ODTNOM];
        end
        REG_STATUS:
        begin
          if (pwdata[ST_ALERT])
            d.alert_seen = 1'b0;
          if (pwdata[ST_ERR])
            d.err = 1'b0;
        end
        default: ;
      endcase
    end

    unique case (q.st)
      S_IDLE:
      begin
        if (q.pend)
        begin
          d.pend = 1'b0;
          d.cnt  = 11'h000;
          d.addr = {4'h0, q.data[13:0]};
          d.ba   = q.mr[1:0];
          d.bg   = {1'b0, q.mr[2]};
          d.act_n = 1'b1;
          d.gap  = TMOD_CYC + 11'(q.pl);
          if (q.pda && !(q.op == OP_PDAMR || q.op == OP_PDAEX))
            d.err = 1'b1;
          else if (q.op == OP_PDAEN && !q.wl_done)
            d.err = 1'b1;
          else if (q.restr && !(q.op == OP_MRS))
            d.err = 1'b1;
          else if (q.need_dll && q.dll_cnt != 11'h000)
            d.pend = 1'b1;
          else
          begin
            d.st     = S_ISSUE;
            d.ck_run = 1'b1;
            unique case (q.op)
              OP_PDAEN:
              begin
                d.ba = MR3_SEL[1:0];
                d.bg = {1'b0, MR3_SEL[2]};
                d.addr[MR3_PDA_BIT] = 1'b1;
              end
              OP_PDAMR: d.gap = pda_gap(q.al, q.cwl, q.bc4, q.pl);
              OP_PDAEX:
              begin
                d.ba = MR3_SEL[1:0];
                d.bg = {1'b0, MR3_SEL[2]};
                d.addr[MR3_PDA_BIT] = 1'b0;
                d.gap = pda_gap(q.al, q.cwl, q.bc4, q.pl);
              end
              OP_SRE:   d.cke = 1'b0;
              OP_SRX:   d.cke = 1'b1;
              OP_PREA:  d.addr[A10_BIT] = 1'b1;
              OP_CKSTP:
              begin
                d.st  = S_CKSTP;
                d.gap = TALERT_CYC + 11'(q.pl);
              end
              default: ;
            endcase
          end
        end
      end
      S_ISSUE:
      begin
        d.cs_n = 1'b0;
        unique case (q.op)
          OP_SRE:  d.addr[16:14] = 3'b001;
          OP_SRX:  d.cs_n = 1'b1;
          OP_PREA: d.addr[16:14] = 3'b010;
          default: d.addr[16:14] = 3'b000;
        endcase
        d.par = even_par(1'b1, {q.addr[17], d.addr[16:14], q.addr[13:0]}, q.ba, q.bg);
        if (q.op == OP_PDAMR || q.op == OP_PDAEX)
        begin
          d.dq_oe = 1'b1;
          d.dq0   = (q.op == OP_PDAMR) ? q.skip : 1'b0;
          d.odt   = q.odt_nom;
        end
        if (q.op == OP_SRX)
        begin
          d.xs_cnt  = TXS_CYC;
          d.dll_cnt = TXSDLL_CYC;
        end
        d.st = S_WAIT;
      end
      S_WAIT:
      begin
        d.cnt = q.cnt + 11'h001;
        // Strobe toggles only over the burst; DQ0 stays put the whole window
        d.dqs = q.dq_oe && (q.cnt >= wl) && (q.cnt < wl + bhalf) ? ~q.dqs : 1'b0;
        if (q.cnt >= q.gap)
        begin
          d.st    = S_IDLE;
          d.dq_oe = 1'b0;
          d.dq0   = 1'b0;
          d.odt   = 1'b0;
          d.dqs   = 1'b0;
          if (q.op == OP_PDAEN)
            d.pda = 1'b1;
          if (q.op == OP_PDAEX)
            d.pda = 1'b0;
        end
      end
      S_CKSTP:
      begin
        d.cnt = q.cnt + 11'h001;
        if (q.cnt >= q.gap)
        begin
          d.ck_run = 1'b0;
          d.st     = S_IDLE;
        end
      end
      S_ALERT:
      begin
        // Device drains and precharges while alert is low
        d.cke = 1'b1;
        if (q.al_s2)
        begin
          d.st   = S_RECOV;
          d.addr = 18'h00000;
          d.addr[A10_BIT] = 1'b1;
          d.addr[16:14]   = 3'b010;
          d.ba   = 2'h0;
          d.bg   = 2'h0;
          d.act_n = 1'b1;
        end
      end
      S_RECOV:
      begin
        // Precharge-all makes both outcomes of the unknown window legal
        d.cs_n = 1'b0;
        d.par  = even_par(1'b1, q.addr, q.ba, q.bg);
        d.op   = OP_PREA;
        d.cnt  = 11'h000;
        d.gap  = TMOD_CYC + 11'(q.pl);
        d.st   = S_WAIT;
      end
      default: d.st = S_IDLE;
    endcase

    // Alert overrides everything: deselect only, clock kept running
    if (!q.al_s2 && q.st != S_ALERT)
    begin
      d.st         = S_ALERT;
      d.cs_n       = 1'b1;
      d.ck_run     = 1'b1;
      d.dq_oe      = 1'b0;
      d.dqs        = 1'b0;
      d.odt        = 1'b0;
      d.alert_seen = 1'b1;
      d.pend       = 1'b0;
      if (q.xs_cnt != 11'h000)
        d.restr = 1'b1;
    end
    else if (q.st == S_ALERT)
      d.cs_n = 1'b1;
  end

  // ==========================================
  // State register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.pl     <= PL_RST;
      q.al     <= AL_RST;
      q.cwl    <= CWL_RST;
      q.cs_n   <= 1'b1;
      q.act_n  <= 1'b1;
      q.cke    <= 1'b1;
      q.ck_run <= 1'b1;
      q.al_s1  <= 1'b1;
      q.al_s2  <= 1'b1;
    end
    else
      q <= d;
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr & q.pready;
  assign ca_cs_n  = q.cs_n;
  assign ca_act_n = q.act_n;
  assign ca_addr  = q.addr;
  assign ca_ba    = q.ba;
  assign ca_bg    = q.bg;
  assign ca_par   = q.par;
  assign cke      = q.cke;
  assign ck_run   = q.ck_run;
  assign odt      = q.odt;
  assign dq0_o    = q.dq0;
  assign dq0_oe   = q.dq_oe;
  assign dqs_o    = q.dqs;
  assign dqs_oe   = q.dq_oe;

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_alert_low;
    !q.al_s2 ##1 1'b1;
  endsequence
  sequence s_desel2;
    ca_cs_n [*2];
  endsequence

  chk_parity_even: assert property (!ca_cs_n |-> !(^{ca_act_n, ca_addr, ca_ba, ca_bg, ca_par}))
    else $error("command parity not even");
  chk_alert_desel: assert property (s_alert_low |-> s_desel2)
    else $error("command issued during alert");
  chk_alert_clock: assert property (!q.al_s2 |=> ck_run)
    else $error("clock stopped during alert");
  chk_dq0_steady: assert property (dq0_oe && $past(dq0_oe) |-> $stable(dq0_o))
    else $error("dq0 changed during burst");
  chk_pda_only_mrs: assert property (q.pda && q.st == S_ISSUE |-> q.op == OP_PDAMR || q.op == OP_PDAEX)
    else $error("non mrs issued in pda");
  chk_pda_exit_dq0: assert property (q.st == S_ISSUE && q.op == OP_PDAEX |=> !ca_cs_n && !dq0_o && dq0_oe
                                     && !ca_addr[MR3_PDA_BIT])
    else $error("pda exit malformed");
  chk_pda_enter_wl: assert property (q.st == S_ISSUE && q.op == OP_PDAEN |-> q.wl_done && ca_addr[MR3_PDA_BIT])
    else $error("pda entered without leveling");
  chk_mrs_spacing: assert property ($fell(ca_cs_n) |=> ca_cs_n [*8])
    else $error("commands spaced too closely");
  chk_dll_wait: assert property (q.st == S_ISSUE && q.need_dll |-> q.dll_cnt == 11'h000)
    else $error("dll command before lock time");
  chk_srx_restr: assert property (q.restr && q.st == S_ISSUE && q.op != OP_PREA |-> q.op == OP_MRS)
    else $error("restricted command after srx alert");
  chk_pda_gap: assert property (q.st == S_ISSUE && q.op == OP_PDAMR
                                |-> q.gap >= wl + bhalf + TMRD_PDA_CYC)
    else $error("pda spacing wrong");
endmodule

// ===== dcpm_dev.sv
// Behavioural device model: CA parity check, alert pulse and per-device MRS gating
`timescale 1ns/100ps
module dcpm_dev
(
  input  wire logic        ref_clk, // CK
  input  wire logic        rst,     // Reset, active high
  input  wire logic        cs_n,    // Chip select, low active
  input  wire logic        act_n,   // Activate, low active
  input  wire logic [17:0] addr,    // Address and command bits
  input  wire logic [1:0]  ba,      // Bank address
  input  wire logic [1:0]  bg,      // Bank group
  input  wire logic        par,     // Parity bit
  input  wire logic        dq0,     // DQ0 level
  input  wire logic        dqs,     // DQS level
  input  wire logic        dqs_oe,  // DQS drive enable
  input  wire logic        inj,     // Corrupt the next command
  output logic             alert_n, // Alert, low active
  output logic             pda,     // Per-device mode active
  output logic             pde,     // Power-down after a bad SRE
  output int               n_exec,  // Gated MRS executed
  output int               n_skip   // Gated MRS ignored
);
  logic [17:0] mr5;
  logic [17:0] pa;
  logic [2:0]  pm;
  logic        perr;
  logic        pend;
  logic        dqs_p;
  int          pw;

  // No dynamic termination and no write CRC flag are modelled at all
  task automatic do_mrs(input logic [17:0] a, input logic [2:0] m);
    if (m == 3'h3)
      pda <= a[4];
    if (m == 3'h5)
    begin
      mr5 <= a;
      if (!a[4])
        perr <= 1'b0;
    end
  endtask

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      alert_n <= 1'b1; pda <= 1'b0; pde <= 1'b0; n_exec <= 0; n_skip <= 0;
      mr5 <= 18'h00000; perr <= 1'b0; pend <= 1'b0; dqs_p <= 1'b0; pw <= 0;
    end
    else
    begin
      dqs_p <= dqs;
      if (pw > 0)
      begin
        pw <= pw - 1;
        alert_n <= (pw == 1);
      end
      // Checking stays off after an error until MR5 bit4 is written zero, unless persistent mode is set
      if (cs_n === 1'b0 && pw == 0 && (^{act_n, addr, ba, bg, par} || inj) && (!perr || mr5[9]))
      begin
        perr <= 1'b1;
        alert_n <= 1'b0;
        pw <= 12;
        if (addr[16:14] == 3'b001)
          pde <= 1'b1;
      end
      else if (cs_n === 1'b0 && addr[16:14] == 3'b000)
      begin
        if (pda)
        begin
          pend <= 1'b1;
          pa <= addr;
          pm <= {bg[0], ba};
        end
        else
          do_mrs(addr, {bg[0], ba});
      end
      // DQ0 decided at the first rising DQS edge of the burst
      if (pend && dqs_oe === 1'b1 && dqs && !dqs_p)
      begin
        pend <= 1'b0;
        if (dq0 === 1'b0)
        begin
          n_exec <= n_exec + 1;
          do_mrs(pa, pm);
        end
        else
          n_skip <= n_skip + 1;
      end
    end
  end
endmodule

// ===== tb_dcpm_ctrl.sv
// Self-checking testbench of the CA parity and per-device MRS controller
`timescale 1ns/100ps
module tb_dcpm_ctrl;
  import dcpm_pkg::*;
  typedef struct {logic [2:0] cmd; logic [13:0] a; logic [2:0] mr; int gap;} dcpm_exp_type;
  logic ref_clk, rst, psel, penable, pwrite, inj;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, ca_cs_n, ca_act_n, ca_par, cke, ck_run, odt;
  logic dq0_o, dq0_oe, dqs_o, dqs_oe, alert_n, pda, pde;
  logic [17:0] ca_addr;
  logic [1:0] ca_ba, ca_bg;
  int n_exec, n_skip, errors, check_count, cyc, last_cs, last_gap, pl, g_n, g_p, n;
  logic bc4, prev_oe, prev_dq;
  logic [31:0] tim;
  logic [17:0] d;
  dcpm_exp_type expq[$];
  dcpm_exp_type e;

  dcpm_ctrl uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ca_cs_n(ca_cs_n), .ca_act_n(ca_act_n),
    .ca_addr(ca_addr), .ca_ba(ca_ba), .ca_bg(ca_bg), .ca_par(ca_par), .cke(cke), .ck_run(ck_run), .odt(odt),
    .dq0_o(dq0_o), .dq0_oe(dq0_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .alert_n(alert_n));
  dcpm_dev dev (.ref_clk(ref_clk), .rst(rst), .cs_n(ca_cs_n), .act_n(ca_act_n), .addr(ca_addr), .ba(ca_ba),
    .bg(ca_bg), .par(ca_par), .dq0(dq0_o), .dqs(dqs_o), .dqs_oe(dqs_oe), .inj(inj), .alert_n(alert_n),
    .pda(pda), .pde(pde), .n_exec(n_exec), .n_skip(n_skip));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Compare and report
  task chk_val(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      errors++;
      $display("ERROR %0t value %h expected %h", $time, g, x);
    end
  endtask
  task chk_gap(input int g, input int x);
    check_count++;
    if (g < x)
    begin
      errors++;
      $display("ERROR %0t spacing %0d below %0d", $time, g, x);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // APB master and command helpers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_idle;
    do
      apb(1'b0, REG_STATUS, 32'h0);
    while (rd[ST_BUSY] !== 1'b0);
  endtask
  task push(input logic [2:0] c, input logic [13:0] a, input logic [2:0] m, input int g);
    expq.push_back('{c, a, m, g});
  endtask
  task issue(input logic [2:0] op, input logic [2:0] m, input logic skip, input logic [17:0] v);
    apb(1'b1, REG_DATA, {14'h0, v});
    apb(1'b1, REG_CMD, {24'h0, 1'b0, skip, m, op});
    wait_idle();
  endtask
  task bad_cmd(input logic [2:0] op);
    inj <= 1'b1;
    apb(1'b1, REG_CMD, {29'h0, op});
    n = 0;
    while (alert_n !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    inj <= 1'b0;
    wait_idle();
  endtask

  // ==========================================
  // Monitor of the command bus against the expected queue
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      errors++;
      $display("ERROR %0t run timed out", $time);
      close_out();
    end
    if (!rst && dq0_oe === 1'b1 && prev_oe === 1'b1)
      chk_val(dq0_o, prev_dq);
    if (!rst && dqs_oe === 1'b1)
      chk_val(odt, tim[TIM_ODTNOM]);
    prev_oe = dq0_oe;
    prev_dq = dq0_o;
    if (!rst && ca_cs_n === 1'b0)
    begin
      chk_val(^{ca_act_n, ca_addr, ca_ba, ca_bg, ca_par}, 1'b0);
      chk_gap(cyc - last_cs, last_gap);
      if (expq.size() == 0)
        chk_val(ca_addr[16:14], 3'h7);
      else
      begin
        e = expq.pop_front();
        chk_val(ca_addr[16:14], e.cmd);
        if (e.cmd == 3'b000)
          chk_val({ca_bg[0], ca_ba, ca_addr[13:0]}, {e.mr, e.a});
        if (e.cmd == 3'b010)
          chk_val(ca_addr[A10_BIT], 1'b1);
        last_gap = e.gap;
      end
      last_cs = cyc;
    end
  end

  // ==========================================
  // Main sequence
  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; inj = 1'b0;
    errors = 0; check_count = 0; cyc = 0; last_cs = -1000; last_gap = 0; tim = 32'h0;
    n = $urandom(99);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk_val(rd & 32'h63, 32'h60);
    apb(1'b0, 8'h10, 32'h0);
    chk_val(rd, 32'h0);
    chk_val(er, 1'b1);
    $display("test reset and map done");
    pl = 4 + $urandom % 3;
    bc4 = $urandom % 2;
    g_n = 24 + pl;
    g_p = 9 + (bc4 ? 2 : 4) + 16 + pl;
    tim = (1 << TIM_ODTNOM) | (bc4 << TIM_BC4) | (9 << TIM_CWL_LSB) | pl;
    apb(1'b1, REG_TIMING, tim);
    for (int m = 0; m < 8; m++)
    begin
      d = $urandom & 18'h03FFF;
      if (m == 3)
        d[4] = 1'b0;
      if (m == 5)
        d = 18'h0;
      push(3'b000, d[13:0], m[2:0], g_n);
      issue(OP_MRS, m[2:0], 1'b0, d);
    end
    $display("test mrs done");
    issue(OP_PDAEN, MR3_SEL, 1'b0, 18'h0);
    chk_val(rd[ST_ERR], 1'b1);
    apb(1'b1, REG_STATUS, 32'h8);
    apb(1'b0, REG_STATUS, 32'h0);
    chk_val(rd[ST_ERR], 1'b0);
    tim = tim | (1 << TIM_WLDONE);
    apb(1'b1, REG_TIMING, tim);
    push(3'b000, 14'h0010, MR3_SEL, g_n);
    issue(OP_PDAEN, MR3_SEL, 1'b0, 18'h0);
    chk_val({rd[ST_PDA], pda}, 2'b11);
    d = $urandom & 18'h03FFF;
    push(3'b000, d[13:0], 3'h1, g_p);
    issue(OP_PDAMR, 3'h1, 1'b1, d);
    chk_val(n_skip, 1);
    push(3'b000, d[13:0], 3'h2, g_p);
    issue(OP_PDAMR, 3'h2, 1'b0, d);
    chk_val(n_exec, 1);
    issue(OP_PREA, 3'h0, 1'b0, 18'h0);
    chk_val(rd[ST_ERR], 1'b1);
    apb(1'b1, REG_STATUS, 32'h8);
    push(3'b000, 14'h0000, MR3_SEL, g_p);
    issue(OP_PDAEX, MR3_SEL, 1'b0, 18'h0);
    chk_val(pda, 1'b0);
    chk_val(n_exec, 2);
    $display("test per-device mode done");
    apb(1'b1, REG_CMD, {29'h0, OP_CKSTP});
    n = 0;
    while (ck_run !== 1'b0 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_gap(n, 10 + pl);
    chk_val(ck_run, 1'b0);
    wait_idle();
    $display("test clock stop done");
    push(3'b000, 14'h0000, 3'h0, 0);
    push(3'b010, 14'h0400, 3'h0, g_n);
    apb(1'b1, REG_DATA, 32'h0);
    bad_cmd(OP_MRS);
    chk_val({rd[ST_ALERT], ck_run}, 2'b11);
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk_val(rd[ST_ALERT], 1'b0);
    push(3'b000, 14'h0200, 3'h5, g_n);
    issue(OP_MRS, 3'h5, 1'b0, 18'h00200);
    $display("test alert done");
    push(3'b001, 14'h0000, 3'h0, 0);
    push(3'b010, 14'h0400, 3'h0, g_n);
    bad_cmd(OP_SRE);
    chk_val({pde, cke}, 2'b11);
    n = cyc;
    issue(OP_SRX, 3'h0, 1'b0, 18'h0);
    chk_val(cke, 1'b1);
    push(3'b000, 14'h0000, 3'h2, g_n);
    apb(1'b1, REG_DATA, 32'h0);
    apb(1'b1, REG_CMD, {24'h0, 1'b1, 1'b0, 3'h2, OP_MRS});
    wait_idle();
    chk_gap(last_cs - n, TXSDLL_CYC);
    chk_val({rd[ST_DLL], rd[ST_RESTR]}, 2'b10);
    $display("test self refresh error done");
    repeat (20) @(posedge ref_clk);
    chk_val(expq.size(), 0);
    close_out();
  end
endmodule
